// ---- logic/pcg_pkg.sv ----
// Shared constants for the port crossbar and general-purpose port block.
package pcg_pkg;
  // ********************************************************************
  // Sizes
  // ********************************************************************
  localparam int PIN_COUNT = 16;
  localparam int SLOT_COUNT = 21;
  localparam int PIN_IDX_W = 4;
  localparam int SLOT_IDX_W = 5;

  // ********************************************************************
  // Register addresses
  // ********************************************************************
  localparam logic [7:0] ADDR_PORT0_DATA = 8'h80;
  localparam logic [7:0] ADDR_PORT1_DATA = 8'h90;
  localparam logic [7:0] ADDR_PORT0_MDOUT = 8'hA4;
  localparam logic [7:0] ADDR_PORT1_MDOUT = 8'hA5;
  localparam logic [7:0] ADDR_PORT0_SKIP = 8'hD4;
  localparam logic [7:0] ADDR_PORT1_SKIP = 8'hD5;
  localparam logic [7:0] ADDR_ROUTE_SEL_A = 8'hE1;
  localparam logic [7:0] ADDR_ROUTE_SEL_B = 8'hE2;
  localparam logic [7:0] ADDR_PORT0_MDIN = 8'hF1;
  localparam logic [7:0] ADDR_PORT1_MDIN = 8'hF2;

  // ********************************************************************
  // Reset values
  // ********************************************************************
  localparam logic [7:0] RST_PORT_DATA = 8'hFF;
  localparam logic [7:0] RST_MDIN = 8'hFF;
  localparam logic [7:0] RST_MDOUT = 8'h00;
  localparam logic [7:0] RST_SKIP = 8'h00;
  localparam logic [7:0] RST_ROUTE_SEL = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // ********************************************************************
  // Field positions of the route select registers
  // ********************************************************************
  localparam int SELA_CMPB_ASYNC = 7;
  localparam int SELA_CMPB_OUT = 6;
  localparam int SELA_CMPA_ASYNC = 5;
  localparam int SELA_CMPA_OUT = 4;
  localparam int SELA_CLK_OUT = 3;
  localparam int SELA_SMBUS = 2;
  localparam int SELA_SPI = 1;
  localparam int SELA_UART = 0;
  localparam int SELB_PULLUP_DIS = 7;
  localparam int SELB_MATRIX_EN = 6;
  localparam int SELB_TIMER_B = 5;
  localparam int SELB_TIMER_A = 4;
  localparam int SELB_EXT_COUNT = 3;
  localparam int SELB_MOD_CNT_LSB = 0;
  localparam int SELB_MOD_CNT_W = 3;

  // ********************************************************************
  // Route slots in priority order, highest first
  // ********************************************************************
  localparam logic [4:0] SLOT_UART_TX = 5'h00;
  localparam logic [4:0] SLOT_UART_RX = 5'h01;
  localparam logic [4:0] SLOT_SPI_SCK = 5'h02;
  localparam logic [4:0] SLOT_SPI_MISO = 5'h03;
  localparam logic [4:0] SLOT_SPI_MOSI = 5'h04;
  localparam logic [4:0] SLOT_SPI_NSS = 5'h05;
  localparam logic [4:0] SLOT_SDA = 5'h06;
  localparam logic [4:0] SLOT_SCL = 5'h07;
  localparam logic [4:0] SLOT_CMPA_OUT = 5'h08;
  localparam logic [4:0] SLOT_CMPA_ASYNC = 5'h09;
  localparam logic [4:0] SLOT_CMPB_OUT = 5'h0A;
  localparam logic [4:0] SLOT_CMPB_ASYNC = 5'h0B;
  localparam logic [4:0] SLOT_CLK_OUT = 5'h0C;
  localparam logic [4:0] SLOT_MOD_PIN0 = 5'h0D;
  localparam logic [4:0] SLOT_EXT_COUNT = 5'h12;
  localparam logic [4:0] SLOT_TIMER_A = 5'h13;
  localparam logic [4:0] SLOT_TIMER_B = 5'h14;
  localparam int MOD_PIN_COUNT = 5;
  localparam int FIRST_FLOAT_SLOT = 2;

  // Fixed pins of the serial port.
  localparam logic [3:0] PIN_UART_TX = 4'h4;
  localparam logic [3:0] PIN_UART_RX = 4'h5;
endpackage

// ---- logic/pcg_xbar_if.sv ----
// Carrier between the register core and the crossbar priority decoder.
`timescale 1ns/1ps
interface pcg_xbar_if;
  logic [pcg_pkg::SLOT_COUNT-1:0] slot_en;
  logic [pcg_pkg::PIN_COUNT-1:0] skip;
  logic [pcg_pkg::SLOT_COUNT-1:0] slot_valid;
  logic [pcg_pkg::SLOT_COUNT-1:0][pcg_pkg::PIN_IDX_W-1:0] slot_pin;

  modport decoder (
    input slot_en,
    input skip,
    output slot_valid,
    output slot_pin
  );
  modport core (
    output slot_en,
    output skip,
    input slot_valid,
    input slot_pin
  );
endinterface

// ---- logic/pcg_xbar_decoder.sv ----
// Priority decoder that gives each enabled slot a pin until the free pins run out.
`timescale 1ns/1ps
module pcg_xbar_decoder (
  pcg_xbar_if.decoder xb
);
  // ********************************************************************
  // Assignment
  // ********************************************************************
  // A slot that finds no free pin stays unrouted rather than sharing one.
  always_comb begin
    logic [pcg_pkg::PIN_COUNT-1:0] taken;
    logic found;
    taken = xb.skip; // (R21)
    found = 1'b0;
    xb.slot_valid = '0;
    xb.slot_pin = '0;
    if (xb.slot_en[pcg_pkg::SLOT_UART_TX]) begin
      taken[pcg_pkg::PIN_UART_TX] = 1'b1; // (R06)
      taken[pcg_pkg::PIN_UART_RX] = 1'b1;
    end
    xb.slot_valid[pcg_pkg::SLOT_UART_TX] = xb.slot_en[pcg_pkg::SLOT_UART_TX];
    xb.slot_valid[pcg_pkg::SLOT_UART_RX] = xb.slot_en[pcg_pkg::SLOT_UART_RX];
    xb.slot_pin[pcg_pkg::SLOT_UART_TX] = pcg_pkg::PIN_UART_TX;
    xb.slot_pin[pcg_pkg::SLOT_UART_RX] = pcg_pkg::PIN_UART_RX;
    for (int s = pcg_pkg::FIRST_FLOAT_SLOT; s < pcg_pkg::SLOT_COUNT;
         s++) begin
      found = 1'b0;
      if (xb.slot_en[s]) begin
        for (int p = 0; p < pcg_pkg::PIN_COUNT; p++) begin
          if (!found && !taken[p]) begin
            found = 1'b1; // (R22)
            taken[p] = 1'b1;
            xb.slot_pin[s] = 4'(p);
          end
        end
      end
      xb.slot_valid[s] = found;
    end
  end
endmodule

// ---- logic/pcg_port_crossbar.sv ----
// Port crossbar and general-purpose port registers, with pin drivers.
// Operation
// (R01) Second comparator async and synced outputs routed only when enabled.
// (R02) First comparator async and synced outputs routed only when enabled.
// (R03) Clock output enable routes the inverted system clock to a pin.
// (R04) SMBus enable routes both data and clock to pins.
// (R05) SPI enable routes the SPI signals to pins.
// (R06) UART enable puts transmit on pin 0.4, receive on 0.5.
// (R07) Pullup disable bit clear enables weak pullups except analog pins.
// (R08) Crossbar enable gates all peripheral-to-pin routing.
// (R09) Timer input enables route each timer input to a pin.
// (R10) External count input enable routes that input to a pin.
// (R11) Three-bit field routes zero to five counter module pins in order.
// (R12) Port writes latch data driving unclaimed pins, 0 low, 1 high.
// (R13) Normal port reads return live pin levels, even on claimed pins.
// (R14) Read-modify-write accesses read the output latch, not the pins.
// (R15) Ports allow byte and bit access and reset to all ones.
// (R16) Open-drain pin with output 1 is left high impedance.
// (R17) Analog-input pins always read as 1.
// (R18) Input mode 0 makes a pin analog: no pullup, driver, receiver.
// (R19) Output mode 1 push-pull, 0 open-drain; resets to all zeros.
// (R20) SMBus pins are always open-drain.
// (R21) Skip bit 1 makes crossbar pass a pin; skips reset zero. UART enable still claims pins 0.4 and 0.5 when skipped.
// (R22) Each resource gets the lowest free, unskipped pin in priority order.
// (R23) Crossbar disabled keeps all pins as inputs with drivers off.
// (R24) Weak pullup only on open-drain pins and off while driving 0.
// (R25) Priority UART, SPI, SMBus, comparators, clock, modules, count, timers.
`timescale 1ns/1ps
module pcg_port_crossbar (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_bit_wr_i,
  input wire logic [2:0] sfr_bit_sel_i,
  input wire logic sfr_bit_val_i,
  input wire logic sfr_rd_i,
  input wire logic sfr_rmw_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic spi_nss_pinned_i,
  input wire logic [pcg_pkg::SLOT_COUNT-1:0] periph_out_i,
  input wire logic [pcg_pkg::SLOT_COUNT-1:0] periph_oe_i,
  output logic [pcg_pkg::SLOT_COUNT-1:0] periph_in_o,
  input wire logic [pcg_pkg::PIN_COUNT-1:0] pin_i,
  output logic [pcg_pkg::PIN_COUNT-1:0] pin_o,
  output logic [pcg_pkg::PIN_COUNT-1:0] pin_oe_n_o,
  output logic [pcg_pkg::PIN_COUNT-1:0] pullup_o
);
  // ********************************************************************
  // Registers
  // ********************************************************************
  logic [7:0] port0_data_reg;
  logic [7:0] port1_data_reg;
  logic [7:0] port0_output_drive_mode_reg;
  logic [7:0] port1_output_drive_mode_reg;
  logic [7:0] port0_route_skip_mask_reg;
  logic [7:0] port1_route_skip_mask_reg;
  logic [7:0] peripheral_route_select_a_reg;
  logic [7:0] peripheral_route_select_b_reg;
  logic [7:0] port0_analog_digital_select_reg;
  logic [7:0] port1_analog_digital_select_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [7:0] port0_data_next;
  logic [7:0] port1_data_next;
  logic [pcg_pkg::PIN_COUNT-1:0] latch;
  logic [pcg_pkg::PIN_COUNT-1:0] digital;
  logic [pcg_pkg::PIN_COUNT-1:0] push_pull;
  logic [pcg_pkg::PIN_COUNT-1:0] pin_level;
  logic route_matrix_enable;
  logic pullup_global_disable;
  logic [2:0] counter_module_pin_count;

  function automatic logic sfr_hit(input logic [7:0] addr,
                                   input logic [7:0] target);
    sfr_hit = (addr == target);
  endfunction

  function automatic logic [7:0] bit_merge(input logic [7:0] value,
                                           input logic [2:0] sel,
                                           input logic bit_val);
    logic [7:0] result;
    result = value;
    result[sel] = bit_val;
    bit_merge = result;
  endfunction

  assign latch = {port1_data_reg, port0_data_reg};
  assign digital = {port1_analog_digital_select_reg,
                    port0_analog_digital_select_reg};
  assign push_pull = {port1_output_drive_mode_reg,
                      port0_output_drive_mode_reg};
  assign pin_level = pin_i | ~digital; // (R17)
  assign route_matrix_enable =
    peripheral_route_select_b_reg[pcg_pkg::SELB_MATRIX_EN];
  assign pullup_global_disable =
    peripheral_route_select_b_reg[pcg_pkg::SELB_PULLUP_DIS];
  assign counter_module_pin_count =
    peripheral_route_select_b_reg[pcg_pkg::SELB_MOD_CNT_LSB +:
                                  pcg_pkg::SELB_MOD_CNT_W];

  // ********************************************************************
  // Port data latches
  // ********************************************************************
  // A bit write merges into the latch, never into the pin level.
  always_comb begin
    port0_data_next = port0_data_reg;
    port1_data_next = port1_data_reg;
    if (sfr_wr_i && sfr_hit(sfr_addr_i, pcg_pkg::ADDR_PORT0_DATA)) begin
      port0_data_next = sfr_wdata_i; // (R12)
    end else if (sfr_bit_wr_i &&
                 sfr_hit(sfr_addr_i, pcg_pkg::ADDR_PORT0_DATA)) begin
      port0_data_next = bit_merge(port0_data_reg, sfr_bit_sel_i,
                                  sfr_bit_val_i); // (R15)
    end
    if (sfr_wr_i && sfr_hit(sfr_addr_i, pcg_pkg::ADDR_PORT1_DATA)) begin
      port1_data_next = sfr_wdata_i; // (R12)
    end else if (sfr_bit_wr_i &&
                 sfr_hit(sfr_addr_i, pcg_pkg::ADDR_PORT1_DATA)) begin
      port1_data_next = bit_merge(port1_data_reg, sfr_bit_sel_i,
                                  sfr_bit_val_i); // (R15)
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port0_data_reg <= pcg_pkg::RST_PORT_DATA; // (R15)
      port1_data_reg <= pcg_pkg::RST_PORT_DATA;
    end else begin
      port0_data_reg <= port0_data_next;
      port1_data_reg <= port1_data_next;
    end
  end

  // ********************************************************************
  // Pin mode registers
  // ********************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port0_output_drive_mode_reg <= pcg_pkg::RST_MDOUT; // (R19)
      port1_output_drive_mode_reg <= pcg_pkg::RST_MDOUT;
      port0_analog_digital_select_reg <= pcg_pkg::RST_MDIN; // (R18)
      port1_analog_digital_select_reg <= pcg_pkg::RST_MDIN;
    end else if (sfr_wr_i) begin
      if (sfr_hit(sfr_addr_i, pcg_pkg::ADDR_PORT0_MDOUT)) begin
        port0_output_drive_mode_reg <= sfr_wdata_i;
      end
      if (sfr_hit(sfr_addr_i, pcg_pkg::ADDR_PORT1_MDOUT)) begin
        port1_output_drive_mode_reg <= sfr_wdata_i;
      end
      if (sfr_hit(sfr_addr_i, pcg_pkg::ADDR_PORT0_MDIN)) begin
        port0_analog_digital_select_reg <= sfr_wdata_i;
      end
      if (sfr_hit(sfr_addr_i, pcg_pkg::ADDR_PORT1_MDIN)) begin
        port1_analog_digital_select_reg <= sfr_wdata_i;
      end
    end
  end

  // ********************************************************************
  // Crossbar configuration registers
  // ********************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port0_route_skip_mask_reg <= pcg_pkg::RST_SKIP; // (R21)
      port1_route_skip_mask_reg <= pcg_pkg::RST_SKIP;
      peripheral_route_select_a_reg <= pcg_pkg::RST_ROUTE_SEL;
      peripheral_route_select_b_reg <= pcg_pkg::RST_ROUTE_SEL;
    end else if (sfr_wr_i) begin
      if (sfr_hit(sfr_addr_i, pcg_pkg::ADDR_PORT0_SKIP)) begin
        port0_route_skip_mask_reg <= sfr_wdata_i;
      end
      if (sfr_hit(sfr_addr_i, pcg_pkg::ADDR_PORT1_SKIP)) begin
        port1_route_skip_mask_reg <= sfr_wdata_i;
      end
      if (sfr_hit(sfr_addr_i, pcg_pkg::ADDR_ROUTE_SEL_A)) begin
        peripheral_route_select_a_reg <= sfr_wdata_i;
      end
      if (sfr_hit(sfr_addr_i, pcg_pkg::ADDR_ROUTE_SEL_B)) begin
        peripheral_route_select_b_reg <= sfr_wdata_i;
      end
    end
  end

  // ********************************************************************
  // Read path
  // ********************************************************************
  always_comb begin
    case (sfr_addr_i)
      pcg_pkg::ADDR_PORT0_DATA: begin
        rdata_next = sfr_rmw_i ? port0_data_reg : pin_level[7:0]; // (R14)
      end
      pcg_pkg::ADDR_PORT1_DATA: begin
        rdata_next = sfr_rmw_i ? port1_data_reg : pin_level[15:8]; // (R13)
      end
      pcg_pkg::ADDR_PORT0_MDOUT: rdata_next = port0_output_drive_mode_reg;
      pcg_pkg::ADDR_PORT1_MDOUT: rdata_next = port1_output_drive_mode_reg;
      pcg_pkg::ADDR_PORT0_SKIP: rdata_next = port0_route_skip_mask_reg;
      pcg_pkg::ADDR_PORT1_SKIP: rdata_next = port1_route_skip_mask_reg;
      pcg_pkg::ADDR_ROUTE_SEL_A: rdata_next = peripheral_route_select_a_reg;
      pcg_pkg::ADDR_ROUTE_SEL_B: rdata_next = peripheral_route_select_b_reg;
      pcg_pkg::ADDR_PORT0_MDIN: rdata_next = port0_analog_digital_select_reg;
      pcg_pkg::ADDR_PORT1_MDIN: rdata_next = port1_analog_digital_select_reg;
      default: rdata_next = pcg_pkg::RD_UNMAPPED;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= pcg_pkg::RD_UNMAPPED;
    end else if (sfr_rd_i) begin
      rdata_reg <= rdata_next;
    end
  end

  assign sfr_rdata_o = rdata_reg;

  // ********************************************************************
  // Route enables and priority decoder
  // ********************************************************************
  pcg_xbar_if xb ();
  logic [pcg_pkg::SLOT_COUNT-1:0] en;

  always_comb begin
    en = '0;
    en[pcg_pkg::SLOT_UART_TX] =
      peripheral_route_select_a_reg[pcg_pkg::SELA_UART]; // (R06)
    en[pcg_pkg::SLOT_UART_RX] =
      peripheral_route_select_a_reg[pcg_pkg::SELA_UART];
    en[pcg_pkg::SLOT_SPI_SCK] =
      peripheral_route_select_a_reg[pcg_pkg::SELA_SPI]; // (R05)
    en[pcg_pkg::SLOT_SPI_MISO] =
      peripheral_route_select_a_reg[pcg_pkg::SELA_SPI];
    en[pcg_pkg::SLOT_SPI_MOSI] =
      peripheral_route_select_a_reg[pcg_pkg::SELA_SPI];
    en[pcg_pkg::SLOT_SPI_NSS] =
      peripheral_route_select_a_reg[pcg_pkg::SELA_SPI] && spi_nss_pinned_i;
    en[pcg_pkg::SLOT_SDA] =
      peripheral_route_select_a_reg[pcg_pkg::SELA_SMBUS]; // (R04)
    en[pcg_pkg::SLOT_SCL] =
      peripheral_route_select_a_reg[pcg_pkg::SELA_SMBUS];
    en[pcg_pkg::SLOT_CMPA_OUT] =
      peripheral_route_select_a_reg[pcg_pkg::SELA_CMPA_OUT]; // (R02)
    en[pcg_pkg::SLOT_CMPA_ASYNC] =
      peripheral_route_select_a_reg[pcg_pkg::SELA_CMPA_ASYNC];
    en[pcg_pkg::SLOT_CMPB_OUT] =
      peripheral_route_select_a_reg[pcg_pkg::SELA_CMPB_OUT]; // (R01)
    en[pcg_pkg::SLOT_CMPB_ASYNC] =
      peripheral_route_select_a_reg[pcg_pkg::SELA_CMPB_ASYNC];
    en[pcg_pkg::SLOT_CLK_OUT] =
      peripheral_route_select_a_reg[pcg_pkg::SELA_CLK_OUT]; // (R03)
    for (int k = 0; k < pcg_pkg::MOD_PIN_COUNT; k++) begin
      en[int'(pcg_pkg::SLOT_MOD_PIN0) + k] =
        (counter_module_pin_count > 3'(k)); // (R11)
    end
    en[pcg_pkg::SLOT_EXT_COUNT] =
      peripheral_route_select_b_reg[pcg_pkg::SELB_EXT_COUNT]; // (R10)
    en[pcg_pkg::SLOT_TIMER_A] =
      peripheral_route_select_b_reg[pcg_pkg::SELB_TIMER_A]; // (R09)
    en[pcg_pkg::SLOT_TIMER_B] =
      peripheral_route_select_b_reg[pcg_pkg::SELB_TIMER_B];
  end

  // Slot numbering itself carries the priority order.
  assign xb.slot_en = en; // (R25)
  assign xb.skip = {port1_route_skip_mask_reg, port0_route_skip_mask_reg};

  pcg_xbar_decoder u_decoder (
    .xb(xb.decoder)
  );

  // ********************************************************************
  // Pin ownership and peripheral inputs
  // ********************************************************************
  logic [pcg_pkg::PIN_COUNT-1:0] own_valid;
  logic [pcg_pkg::PIN_COUNT-1:0][pcg_pkg::SLOT_IDX_W-1:0] own_slot;

  always_comb begin
    own_valid = '0;
    own_slot = '0;
    periph_in_o = '1;
    for (int s = 0; s < pcg_pkg::SLOT_COUNT; s++) begin
      if (xb.slot_valid[s] && route_matrix_enable) begin
        own_valid[xb.slot_pin[s]] = 1'b1; // (R08)
        own_slot[xb.slot_pin[s]] = 5'(s);
        periph_in_o[s] = pin_level[xb.slot_pin[s]];
      end
    end
  end

  // ********************************************************************
  // Pin drivers
  // ********************************************************************
  logic [pcg_pkg::PIN_COUNT-1:0] drive;
  logic [pcg_pkg::PIN_COUNT-1:0] open_drain;

  generate
    for (genvar g = 0; g < pcg_pkg::PIN_COUNT; g++) begin : g_pin
      logic val;
      logic want;
      logic smbus_pin;
      assign smbus_pin = own_valid[g] &&
        (own_slot[g] == pcg_pkg::SLOT_SDA ||
         own_slot[g] == pcg_pkg::SLOT_SCL);
      assign val = own_valid[g] ? periph_out_i[own_slot[g]] : latch[g];
      assign want = own_valid[g] ? periph_oe_i[own_slot[g]] : 1'b1;
      assign open_drain[g] = !push_pull[g] || smbus_pin; // (R20)
      // An open-drain high is released so several parties can share it.
      assign drive[g] = route_matrix_enable && digital[g] && want &&
        (!open_drain[g] || !val); // (R16)
      assign pin_o[g] = val;
      assign pin_oe_n_o[g] = !drive[g]; // (R23)
      assign pullup_o[g] = !pullup_global_disable && digital[g] && // (R07)
        open_drain[g] && !(drive[g] && !val); // (R24)
    end
  endgenerate

  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence seq_p0_write;
    sfr_wr_i && sfr_addr_i == pcg_pkg::ADDR_PORT0_DATA;
  endsequence
  sequence seq_p0_rmw_read;
    sfr_rd_i && sfr_rmw_i && sfr_addr_i == pcg_pkg::ADDR_PORT0_DATA &&
    !sfr_wr_i && !sfr_bit_wr_i;
  endsequence

  chk_rmw_reads_latch: assert property ( // (R14)
    seq_p0_write ##1 seq_p0_rmw_read |=> sfr_rdata_o == $past(sfr_wdata_i, 2))
    else $error("rmw read did not return the latched value");
  chk_pin_read_live: assert property ( // (R13)
    sfr_rd_i && !sfr_rmw_i && sfr_addr_i == pcg_pkg::ADDR_PORT1_DATA
    |=> sfr_rdata_o == $past(pin_i[15:8] | ~digital[15:8]))
    else $error("port read did not return pin levels");
  chk_bit_write: assert property ( // (R15)
    sfr_bit_wr_i && !sfr_wr_i && sfr_addr_i == pcg_pkg::ADDR_PORT0_DATA
    |=> port0_data_reg[$past(sfr_bit_sel_i)] == $past(sfr_bit_val_i))
    else $error("bit write did not reach the latch");
  chk_reset_ones: assert property ( // (R15)
    $past(rst_i) && !rst_i |-> latch == {2{pcg_pkg::RST_PORT_DATA}})
    else $error("port latches not all ones after reset");
  chk_matrix_off: assert property ( // (R23)
    !route_matrix_enable |-> pin_oe_n_o == '1)
    else $error("pin driven while crossbar disabled");
  chk_analog_quiet: assert property ( // (R18)
    ((~digital & (~pin_oe_n_o | pullup_o)) == '0))
    else $error("analog pin has driver or pullup active");
  chk_od_release: assert property ( // (R16)
    ((drive & open_drain & pin_o) == '0))
    else $error("open-drain pin driven high");
  chk_pullup_disable: assert property ( // (R07)
    pullup_global_disable |-> pullup_o == '0)
    else $error("pullup on while globally disabled");
  chk_uart_fixed: assert property ( // (R06)
    route_matrix_enable && en[pcg_pkg::SLOT_UART_TX] &&
    digital[pcg_pkg::PIN_UART_TX]
    |-> pin_o[pcg_pkg::PIN_UART_TX] == periph_out_i[pcg_pkg::SLOT_UART_TX])
    else $error("uart transmit not on its fixed pin");
  chk_skip_kept: assert property ( // (R21)
    ((own_valid & xb.skip & ~{pcg_pkg::PIN_COUNT{en[0]}}) == '0))
    else $error("crossbar assigned a skipped pin");
endmodule

// ---- verification/pcg_pin_model.sv ----
// Behavioural model of the board circuitry on the port pins.
`timescale 1ns/1ps
module pcg_pin_model (
  input wire logic [15:0] pin_o_i,
  input wire logic [15:0] pin_oe_n_i,
  input wire logic [15:0] pullup_i,
  input wire logic [15:0] ext_drv_i,
  input wire logic ext_en_i,
  output logic [15:0] level_o
);
  // A floating pin shows the inverse of the device value, so that an
  // undriven line never passes for a held one.
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (!pin_oe_n_i[i]) level_o[i] = pin_o_i[i];
      else if (ext_en_i) level_o[i] = ext_drv_i[i];
      else if (pullup_i[i]) level_o[i] = 1'b1;
      else level_o[i] = ~pin_o_i[i];
    end
  end
endmodule

// ---- verification/tb_top.sv ----
// Self-checking bench for the port crossbar and port registers.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
  logic clk_i = 0, rst_i = 1, sfr_wr_i = 0, sfr_bit_wr_i = 0, sfr_rd_i = 0;
  logic sfr_rmw_i = 0, sfr_bit_val_i = 0, ext_en = 0, spi_nss_pinned_i = 1;
  logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o, rv;
  logic [2:0] sfr_bit_sel_i = 3'h0;
  logic [20:0] periph_out_i = 21'h0, periph_oe_i = 21'h0, periph_in_o;
  logic [15:0] pin_i, pin_o, pin_oe_n_o, pullup_o, ext_drv = 16'h0000;
  logic [7:0] ra [11] = '{8'h80, 8'h90, 8'hA4, 8'hA5, 8'hD4, 8'hD5, 8'hE1,
    8'hE2, 8'hF1, 8'hF2, 8'h33};
  logic [7:0] re [11] = '{8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'hFF, 8'hFF, 8'h00};
  int fail_count = 0, comparisons = 0, pins_used = 0;
  always #2.5 clk_i = ~clk_i;
  pcg_port_crossbar pcg_port_crossbar_i (.clk_i, .rst_i, .sfr_addr_i,
    .sfr_wr_i, .sfr_wdata_i, .sfr_bit_wr_i, .sfr_bit_sel_i, .sfr_bit_val_i,
    .sfr_rd_i, .sfr_rmw_i, .sfr_rdata_o, .spi_nss_pinned_i,
    .periph_out_i, .periph_oe_i, .periph_in_o, .pin_i, .pin_o, .pin_oe_n_o,
    .pullup_o);
  pcg_pin_model pcg_pin_model_i (.pin_o_i(pin_o), .pin_oe_n_i(pin_oe_n_o),
    .pullup_i(pullup_o), .ext_drv_i(ext_drv), .ext_en_i(ext_en),
    .level_o(pin_i));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(posedge clk_i);
    #1 sfr_wr_i = 1'b0;
    @(posedge clk_i);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic m);
    sfr_addr_i = a;
    sfr_rmw_i = m;
    sfr_rd_i = 1'b1;
    @(posedge clk_i);
    #1 sfr_rd_i = 1'b0;
    rv = sfr_rdata_o;
    @(posedge clk_i);
    #1;
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #20000 fail_count++;
    give_verdict();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    #1 rst_i = 1'b0;
    // The unmapped address 0x33 sits at the end of the table.
    for (int i = 0; i < 11; i++) begin
      rd(ra[i], 1'b1);
      `CHK(rv, re[i])
    end
    `CHK(pin_oe_n_o, 16'hFFFF)
    `CHK(pullup_o, 16'hFFFF)
    $display("reset values done");
    ext_en = 1'b1;
    ext_drv = 16'h3CC3;
    rd(8'h80, 1'b0);
    `CHK(rv, 8'hC3)
    rd(8'h90, 1'b0);
    `CHK(rv, 8'h3C)
    wr(8'hF1, 8'hF0);
    rd(8'h80, 1'b0);
    `CHK(rv, 8'hCF)
    `CHK(pullup_o[3:0], 4'h0)
    wr(8'hF1, 8'hFF);
    wr(8'hE2, 8'h80);
    `CHK(pullup_o, 16'h0000)
    ext_en = 1'b0;
    $display("pin reads done");
    sfr_addr_i = 8'h80;
    sfr_wdata_i = 8'h5A;
    sfr_wr_i = 1'b1;
    @(posedge clk_i);
    #1 sfr_wr_i = 1'b0;
    sfr_rd_i = 1'b1;
    sfr_rmw_i = 1'b1;
    @(posedge clk_i);
    #1 sfr_rd_i = 1'b0;
    `CHK(sfr_rdata_o, 8'h5A)
    sfr_bit_wr_i = 1'b1;
    sfr_bit_val_i = 1'b1;
    sfr_addr_i = 8'h80;
    @(posedge clk_i);
    #1 sfr_bit_wr_i = 1'b0;
    rd(8'h80, 1'b1);
    `CHK(rv, 8'h5B)
    wr(8'hE2, 8'h40);
    `CHK(pin_oe_n_o, 16'hFF5B)
    `CHK(pullup_o, 16'hFF5B)
    wr(8'hA4, 8'hFF);
    `CHK(pin_oe_n_o[7:0], 8'h00)
    `CHK(pin_o[7:0], 8'h5B)
    `CHK(pullup_o[7:0], 8'h00)
    $display("port output done");
    periph_oe_i = 21'h00E001;
    wr(8'hE1, 8'h01);
    ext_en = 1'b1;
    @(posedge clk_i);
    #1 `CHK({pin_o[4], pin_oe_n_o[4], periph_in_o[1]}, 3'h0)
    ext_en = 1'b0;
    periph_oe_i = 21'h0000C0;
    periph_out_i = 21'h000080;
    wr(8'hE1, 8'h04);
    `CHK({pin_o[0], pin_oe_n_o[1:0]}, 3'h2)
    wr(8'hD4, 8'h01);
    `CHK(pin_oe_n_o[2:0], 3'h4)
    wr(8'hE1, 8'h00);
    wr(8'hD4, 8'h00);
    wr(8'h80, 8'hFF);
    periph_oe_i = 21'h03E000;
    periph_out_i = 21'h000000;
    for (int k = 0; k < 8; k++) begin
      wr(8'hE2, 8'h40 | 8'(k));
      `CHK(pin_o[4:0], 5'h1F << (k > 5 ? 5 : k))
    end
    periph_oe_i = 21'h1FFFFF;
    for (int j = 1; j < 11; j++) begin
      pins_used = (j == 1) ? 4 : (j == 2) ? 2 : 1;
      wr(8'hE1, j < 8 ? 8'h01 << j : 8'h00);
      wr(8'hE2, j < 8 ? 8'h40 : 8'h40 | (8'h01 << (j - 5)));
      `CHK(pin_o[7:0], 8'hFF << pins_used)
    end
    periph_out_i = 21'h1426D0;
    wr(8'hE1, 8'hFE);
    wr(8'hE2, 8'h79);
    `CHK(pin_o, 16'hD9B4)
    wr(8'hE1, 8'h04);
    wr(8'hE2, 8'h00);
    `CHK({pin_oe_n_o, periph_in_o}, {16'hFFFF, 21'h1FFFFF})
    $display("routing done");
    give_verdict();
  end
endmodule
